// file: src/mcctb_top.sv
// main clock controller with time base, clock-out and tone output
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mcctb_cfg.svh"
// ================================================================
module mcctb_top
   import mcctb_pkg::*;
#(
   parameter int unsigned TB_P3 = 200000 // longest period, shortenable
) (
   input  wire  logic        aclk,
   input  wire  logic        aresetn,
   // axi4-lite write address
   input  wire  logic [11:0] s_axi_awaddr,
   input  wire  logic        s_axi_awvalid,
   output logic              s_axi_awready,
   // axi4-lite write data
   input  wire  logic [31:0] s_axi_wdata,
   input  wire  logic [3:0]  s_axi_wstrb,
   input  wire  logic        s_axi_wvalid,
   output logic              s_axi_wready,
   // axi4-lite write response
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire  logic        s_axi_bready,
   // axi4-lite read address
   input  wire  logic [11:0] s_axi_araddr,
   input  wire  logic        s_axi_arvalid,
   output logic              s_axi_arready,
   // axi4-lite read data
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire  logic        s_axi_rready,
   // cpu side
   input  wire  logic        cpu_irq_masked,
   input  wire  logic        halt_request,
   input  wire  logic        wait_request,
   input  wire  logic        halt_wake,
   output logic [1:0]        power_state,
   output logic              cpu_clk_en,
   output logic              clock_out_pin,
   output logic              clock_out_sel,
   output logic              tone_pin,
   output logic              tone_sel,
   output logic              timebase_irq,
   output logic              irq
);
   // ================================================================
   // registers and state
   logic [7:0]   csr_r;          // control/status byte
   logic [1:0]   tone_r;         // tone select
   logic [0:0]   irq_mask_r;     // interrupt mask, same layout as status
   logic [0:0]   irq_stat_r;     // sticky event status
   logic [1:0]   tb_active_r;    // period in force
   logic [17:0]  tb_cnt_r;       // time-base counter
   logic [3:0]   div_cnt_r;      // cpu clock divider
   logic         cpu_en_r;       // cpu clock enable
   logic         clkout_r;       // clock-out toggle
   logic [12:0]  tone_cnt_r;     // tone half-period counter
   logic         tone_r_q;       // tone output level
   mcctb_power_e pwr_r;          // power state
   logic         tb_wrap;        // period end this cycle
   logic [17:0]  tb_period;      // period in cycles
   logic         frozen;         // registers frozen
   logic         rd_fire;        // read taken this cycle
   logic         wr_fire;        // write taken this cycle
   logic [11:0]  rd_addr;        // read address
   logic [4:0]   div_last;       // divider last count
   // ================================================================
   // power state
   assign frozen = (pwr_r == MCCTB_ACTIVE_HALT) || (pwr_r == MCCTB_HALT);
   // power state machine driven by the sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwr_r <= MCCTB_RUN;
      end else begin
         unique case (pwr_r)
            MCCTB_RUN: begin
               if (halt_request) begin
                  // enable bit picks active-halt over halt
                  pwr_r <= csr_r[`MCCTB_CSR_IE] ? MCCTB_ACTIVE_HALT : MCCTB_HALT;
               end else if (wait_request) begin
                  pwr_r <= MCCTB_WAIT;
               end
            end
            // time-base irq or other wake leaves wait
            MCCTB_WAIT: if (timebase_irq || halt_wake) pwr_r <= MCCTB_RUN;
            MCCTB_ACTIVE_HALT: if (tb_wrap || halt_wake) pwr_r <= MCCTB_RUN;
            // only an external wake leaves full halt
            MCCTB_HALT: if (halt_wake) pwr_r <= MCCTB_RUN;
         endcase
      end
   end
   assign power_state = pwr_r;
   // ================================================================
   // time-base counter
   always_comb begin
      unique case (tb_active_r)
         2'd0: tb_period = `MCCTB_TB_P0;
         2'd1: tb_period = `MCCTB_TB_P1;
         2'd2: tb_period = `MCCTB_TB_P2;
         2'd3: tb_period = 18'(TB_P3);
      endcase
   end
   assign tb_wrap = (pwr_r != MCCTB_HALT) && (tb_cnt_r == tb_period - 18'd1);
   // free-running counter, stopped only in full halt
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tb_cnt_r    <= 18'd0;
         tb_active_r <= 2'd0;
      end else if (pwr_r != MCCTB_HALT) begin
         if (tb_wrap) begin
            tb_cnt_r    <= 18'd0;
            // selection loaded only at period end
            tb_active_r <= csr_r[`MCCTB_CSR_TB_HI:`MCCTB_CSR_TB_LO];
         end else begin
            tb_cnt_r <= tb_cnt_r + 18'd1;
         end
      end
   end
   // ================================================================
   // cpu clock divider
   always_comb begin
      unique case (csr_r[`MCCTB_CSR_DIV_HI:`MCCTB_CSR_DIV_LO])
         2'd0: div_last = 5'd1;
         2'd1: div_last = 5'd3;
         2'd2: div_last = 5'd7;
         2'd3: div_last = 5'd15;
      endcase
   end
   // one-cycle enable every divisor cycles in slow mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt_r <= 4'd0;
         cpu_en_r  <= 1'b0;
      end else if (!csr_r[`MCCTB_CSR_SLOW]) begin
         div_cnt_r <= 4'd0;
         cpu_en_r  <= 1'b1;
      end else if ({1'b0, div_cnt_r} >= div_last) begin
         div_cnt_r <= 4'd0;
         cpu_en_r  <= 1'b1;
      end else begin
         div_cnt_r <= div_cnt_r + 4'd1;
         cpu_en_r  <= 1'b0;
      end
   end
   assign cpu_clk_en = cpu_en_r;
   // ================================================================
   // clock-out: toggles on each cpu clock tick outside active-halt
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clkout_r <= 1'b0;
      end else if (!csr_r[`MCCTB_CSR_CLKOUT] || pwr_r == MCCTB_ACTIVE_HALT) begin
         clkout_r <= 1'b0;
      end else if (cpu_en_r) begin
         clkout_r <= ~clkout_r;
      end
   end
   assign clock_out_pin = clkout_r;
   assign clock_out_sel = csr_r[`MCCTB_CSR_CLKOUT];
   // ================================================================
   // tone generator, square wave at half-period count
   logic [12:0] tone_half; // half period for current select
   always_comb begin
      unique case (tone_r)
         2'd0: tone_half = 13'd1;
         2'd1: tone_half = `MCCTB_TONE_H1;
         2'd2: tone_half = `MCCTB_TONE_H2;
         2'd3: tone_half = `MCCTB_TONE_H3;
      endcase
   end
   // half-period counter, held at zero when off or in full halt
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tone_cnt_r <= 13'd0;
         tone_r_q   <= 1'b0;
      end else if (tone_r == 2'd0 || pwr_r == MCCTB_HALT) begin
         tone_cnt_r <= 13'd0;
         tone_r_q   <= 1'b0;
      end else if (tone_cnt_r >= tone_half - 13'd1) begin
         tone_cnt_r <= 13'd0;
         tone_r_q   <= ~tone_r_q;
      end else begin
         tone_cnt_r <= tone_cnt_r + 13'd1;
      end
   end
   assign tone_pin = tone_r_q;
   assign tone_sel = (tone_r != 2'd0);
   // ================================================================
   // axi4-lite slave: write path
   logic        aw_held_r;  // address accepted
   logic        w_held_r;   // data accepted
   logic [11:0] aw_addr_r;  // held address
   logic [31:0] w_data_r;   // held data
   logic [3:0]  w_strb_r;   // held strobes
   logic        bvalid_r;   // response pending
   logic [1:0]  bresp_r;    // response code
   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready  = !w_held_r && !bvalid_r;
   assign wr_fire       = aw_held_r && w_held_r && !bvalid_r;
   // capture address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         aw_addr_r <= 12'h000;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_r <= 1'b0;
         end
      end
   end
   // write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= 2'b00;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         unique case (aw_addr_r)
            `MCCTB_OFF_CSR, `MCCTB_OFF_TONE, `MCCTB_OFF_IRQ_STAT,
            `MCCTB_OFF_IRQ_MASK, `MCCTB_OFF_POWER: bresp_r <= 2'b00;
            default: bresp_r <= 2'b10; // unmapped: slverr
         endcase
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp  = bresp_r;
   // ================================================================
   // axi4-lite slave: read path
   logic        rvalid_r; // read data pending
   logic [31:0] rdata_r;  // read data
   logic [1:0]  rresp_r;  // read response
   assign s_axi_arready = !rvalid_r;
   assign rd_fire       = s_axi_arvalid && !rvalid_r;
   assign rd_addr       = s_axi_araddr;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= 2'b00;
      end else if (rd_fire) begin
         rvalid_r <= 1'b1;
         rresp_r  <= 2'b00;
         unique case (rd_addr)
            `MCCTB_OFF_CSR:      rdata_r <= {24'h00_0000, csr_r[7:1], csr_r[0] | tb_wrap};
            `MCCTB_OFF_TONE:     rdata_r <= {30'h0000_0000, tone_r};
            `MCCTB_OFF_IRQ_STAT: rdata_r <= {31'h0000_0000, irq_stat_r};
            `MCCTB_OFF_IRQ_MASK: rdata_r <= {31'h0000_0000, irq_mask_r};
            `MCCTB_OFF_POWER:    rdata_r <= {30'h0000_0000, pwr_r};
            default: begin
               rdata_r <= 32'h0000_0000;
               rresp_r <= 2'b10;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata  = rdata_r;
   assign s_axi_rresp  = rresp_r;
   // ================================================================
   // control/status register; frozen while halted
   logic csr_wr; // write hits control/status
   logic csr_rd; // read hits control/status
   assign csr_wr = wr_fire && aw_addr_r == `MCCTB_OFF_CSR && w_strb_r[0] && !frozen;
   assign csr_rd = rd_fire && rd_addr == `MCCTB_OFF_CSR;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         csr_r <= `MCCTB_CSR_RST;
      end else begin
         if (csr_wr) begin
            // flag bit is not writable
            csr_r[7:1] <= w_data_r[7:1];
         end
         // a wrap wins over a read clear
         if (tb_wrap) begin
            csr_r[`MCCTB_CSR_FLAG] <= 1'b1;
         end else if (csr_rd) begin
            csr_r[`MCCTB_CSR_FLAG] <= 1'b0;
         end
      end
   end
   // tone register and interrupt mask
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tone_r     <= `MCCTB_TONE_RST;
         irq_mask_r <= 1'b0;
      end else if (wr_fire && w_strb_r[0] && !frozen) begin
         if (aw_addr_r == `MCCTB_OFF_TONE) tone_r <= w_data_r[1:0];
         if (aw_addr_r == `MCCTB_OFF_IRQ_MASK) irq_mask_r <= w_data_r[0:0];
      end
   end
   // sticky status: set wins over read clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_r <= 1'b0;
      end else if (tb_wrap) begin
         irq_stat_r <= 1'b1;
      end else if (rd_fire && rd_addr == `MCCTB_OFF_IRQ_STAT) begin
         irq_stat_r <= 1'b0;
      end
   end
   // interrupt request to the cpu
   assign timebase_irq = csr_r[`MCCTB_CSR_FLAG] && csr_r[`MCCTB_CSR_IE] && !cpu_irq_masked;
   assign irq          = |(irq_stat_r & irq_mask_r);
   // ================================================================
   // checks
   a_flag_on_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
      tb_wrap |=> csr_r[0]) else $error("flag not set after wrap");
   a_flag_read_clr: assert property (@(posedge aclk) disable iff (!aresetn)
      csr_rd && !tb_wrap |=> !csr_r[0]) else $error("flag not cleared by read");
   // the enable is still at its reset level on the first edge after release
   a_normal_clock: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && !csr_r[4] && !$past(csr_r[4]) |-> cpu_en_r)
      else $error("cpu clock gated in normal");
   a_slow_div_two: assert property (@(posedge aclk) disable iff (!aresetn)
      (csr_r[6:4] == 3'b001)[*4] |-> (cpu_en_r != $past(cpu_en_r)))
      else $error("divide by two wrong");
   a_clkout_halt: assert property (@(posedge aclk) disable iff (!aresetn)
      pwr_r == MCCTB_ACTIVE_HALT |=> !clkout_r) else $error("clock-out toggles in halt");
   a_halt_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
      pwr_r == MCCTB_HALT && $past(pwr_r) == MCCTB_HALT |-> $stable(tb_cnt_r))
      else $error("counter runs in halt");
   a_halt_select: assert property (@(posedge aclk) disable iff (!aresetn)
      pwr_r == MCCTB_RUN && halt_request && csr_r[1] |=> pwr_r == MCCTB_ACTIVE_HALT)
      else $error("active-halt not entered");
   a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      timebase_irq |-> csr_r[1] && !cpu_irq_masked) else $error("irq without enable");
   a_irq_raise: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(tb_wrap) && csr_r[1] && !cpu_irq_masked |-> timebase_irq)
      else $error("irq not raised after wrap");
   a_period_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !tb_wrap |=> $stable(tb_active_r)) else $error("period changed mid-run");
endmodule
`default_nettype wire

// file: src/mcctb_cfg.svh
// constants for the main clock / time-base / tone block
`ifndef MCCTB_CFG_SVH
`define MCCTB_CFG_SVH
// register byte offsets on the axi4-lite slave
`define MCCTB_OFF_CSR      12'h000
`define MCCTB_OFF_TONE     12'h004
`define MCCTB_OFF_IRQ_STAT 12'h008
`define MCCTB_OFF_IRQ_MASK 12'h00C
`define MCCTB_OFF_POWER    12'h010
// control/status field positions
`define MCCTB_CSR_CLKOUT   7
`define MCCTB_CSR_DIV_HI   6
`define MCCTB_CSR_DIV_LO   5
`define MCCTB_CSR_SLOW     4
`define MCCTB_CSR_TB_HI    3
`define MCCTB_CSR_TB_LO    2
`define MCCTB_CSR_IE       1
`define MCCTB_CSR_FLAG     0
// reset values
`define MCCTB_CSR_RST      8'h00
`define MCCTB_TONE_RST     2'h0
// time-base periods in oscillator cycles
`define MCCTB_TB_P0        18'd16000
`define MCCTB_TB_P1        18'd32000
`define MCCTB_TB_P2        18'd80000
`define MCCTB_TB_P3        18'd200000
// tone half periods in oscillator cycles (8 mhz: 2 khz, 1 khz, 500 hz)
`define MCCTB_TONE_H1      13'd2000
`define MCCTB_TONE_H2      13'd4000
`define MCCTB_TONE_H3      13'd8000
`endif

// file: src/mcctb_pkg.sv
// types for the main clock / time-base / tone block
package mcctb_pkg;
   // power state as told by the power sequencer
   typedef enum logic [1:0] {
      MCCTB_RUN,
      MCCTB_WAIT,
      MCCTB_ACTIVE_HALT,
      MCCTB_HALT
   } mcctb_power_e;
   // axi response code
   typedef logic [1:0] mcctb_resp_t;
endpackage

// file: testbench/mcctb_cpu_model.sv
// cpu-side consumer model: measures cpu tick spacing and clock-out toggle spacing
`timescale 1ns/1ps
`default_nettype none
module mcctb_cpu_model (
   input  wire logic aclk,
   input  wire logic cpu_clk_en,
   input  wire logic clock_out_pin,
   output var  int   tick_gap,
   output var  int   cout_gap
);
   int   tick_cnt = 0;    // cycles since the last cpu tick
   int   cout_cnt = 0;    // cycles since the last clock-out edge
   logic cout_q   = 1'b0; // clock-out level one cycle ago
   // ================================================================
   // tick spacing: the core only advances on a tick
   always @(posedge aclk) begin
      tick_cnt <= cpu_clk_en ? 1 : tick_cnt + 1;
      if (cpu_clk_en) begin
         tick_gap <= tick_cnt;
      end
   end
   // ================================================================
   // clock-out edge spacing, as an external device would see it
   always @(posedge aclk) begin
      cout_q   <= clock_out_pin;
      cout_cnt <= (clock_out_pin != cout_q) ? 1 : cout_cnt + 1;
      if (clock_out_pin != cout_q) begin
         cout_gap <= cout_cnt;
      end
   end
endmodule
`default_nettype wire

// file: testbench/main_clock_ctrl_rtc_beeper_test.sv
// self-checking bench for the clock divider, time base and tone block
`timescale 1ns/1ps
`default_nettype none
`include "mcctb_cfg.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module main_clock_ctrl_rtc_beeper_test;
   import mcctb_pkg::*;
   localparam int P3 = 64; // shortened longest period
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, rdat;
   logic [3:0]  wstrb = 4'hF;
   logic [1:0]  bresp, rresp, rrsp, power_state;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        cpu_irq_masked = 0, halt_request = 0, wait_request = 0, halt_wake = 0;
   logic        awready, wready, bvalid, arready, rvalid, lv;
   logic        cpu_clk_en, clock_out_pin, clock_out_sel, tone_pin, tone_sel;
   logic        timebase_irq, irq;
   int          failures = 0, n_compared = 0, cyc = 0, tick_gap, cout_gap, t0, n;
   // ================================================================
   // clock, cycle count, design and consumer model
   initial begin
      forever #4 aclk = ~aclk;
   end
   always @(posedge aclk) cyc <= cyc + 1;
   mcctb_top #(.TB_P3(P3)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .cpu_irq_masked(cpu_irq_masked), .halt_request(halt_request),
      .wait_request(wait_request), .halt_wake(halt_wake), .power_state(power_state),
      .cpu_clk_en(cpu_clk_en), .clock_out_pin(clock_out_pin),
      .clock_out_sel(clock_out_sel), .tone_pin(tone_pin), .tone_sel(tone_sel),
      .timebase_irq(timebase_irq), .irq(irq));
   mcctb_cpu_model u_cpu (.aclk(aclk), .cpu_clk_en(cpu_clk_en),
      .clock_out_pin(clock_out_pin), .tick_gap(tick_gap), .cout_gap(cout_gap));
   // ================================================================
   // verdict and bounded waits
   task automatic tally_and_finish();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic hang(); // a bounded wait ran out
      failures++;
      tally_and_finish();
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: return timebase_irq;
         1: return irq;
         2: return tone_pin;
         default: return power_state == 2'd0;
      endcase
   endfunction
   task automatic wait_for(input int s, input logic lvl, input int lim);
      int k;
      k = 0;
      while (pick(s) !== lvl) begin
         @(posedge aclk);
         if (++k > lim) hang();
      end
   endtask
   // ================================================================
   // axi4-lite master: writes with the current wstrb, never bit-modify
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int k;
      k = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (++k > 50) hang();
      end while (awvalid || wvalid);
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (++k > 100) hang();
      end while (!bvalid);
      bready <= 1'b0;
      `CHK(bresp, er)
   endtask
   task automatic rd(input logic [11:0] a);
      int k;
      k = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (++k > 50) hang();
      end while (!arready);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (++k > 100) hang();
      end while (!rvalid);
      rready <= 1'b0;
      rdat = rdata;
      rrsp = rresp;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      rd(a);
      `CHK(rdat, e)
      `CHK(rrsp, er)
   endtask
   task automatic pulse(input int s); // one-cycle request to the power logic
      if (s == 0) halt_request <= 1'b1; else if (s == 1) wait_request <= 1'b1;
      else halt_wake <= 1'b1;
      @(posedge aclk);
      halt_request <= 1'b0;
      wait_request <= 1'b0;
      halt_wake <= 1'b0;
      @(posedge aclk);
   endtask
   // ================================================================
   // main sequence
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd_chk(`MCCTB_OFF_CSR, 32'h0000_0000, 2'b00);
      rd_chk(`MCCTB_OFF_TONE, 32'h0000_0000, 2'b00);
      rd_chk(12'h020, 32'h0000_0000, 2'b10);
      wr(12'h020, 32'h0000_0001, 2'b10);
      wstrb <= 4'h0;
      wr(`MCCTB_OFF_CSR, 32'h0000_00FE, 2'b00);
      wstrb <= 4'hF;
      rd_chk(`MCCTB_OFF_CSR, 32'h0000_0000, 2'b00);
      for (int d = 0; d < 4; d++) begin
         wr(`MCCTB_OFF_CSR, 32'h0000_0090 | (32'(d) << 5), 2'b00);
         repeat (40) @(posedge aclk);
         `CHK(tick_gap, 2 << d)
         `CHK(cout_gap, 2 << d)
         `CHK(clock_out_sel, 1'b1)
      end
      wr(`MCCTB_OFF_CSR, 32'h0000_0000, 2'b00);
      repeat (40) @(posedge aclk);
      `CHK(tick_gap, 1)
      `CHK(clock_out_sel, 1'b0)
      $display("test clock divider done");
      cpu_irq_masked <= 1'b1;
      wr(`MCCTB_OFF_IRQ_MASK, 32'h0000_0001, 2'b00);
      wr(`MCCTB_OFF_CSR, 32'h0000_000E, 2'b00);
      wait_for(1, 1'b1, 17000);
      `CHK(timebase_irq, 1'b0)
      rd_chk(`MCCTB_OFF_CSR, 32'h0000_000F, 2'b00);
      rd_chk(`MCCTB_OFF_CSR, 32'h0000_000E, 2'b00);
      rd_chk(`MCCTB_OFF_IRQ_STAT, 32'h0000_0001, 2'b00);
      `CHK(irq, 1'b0)
      cpu_irq_masked <= 1'b0;
      wait_for(0, 1'b1, 100);
      t0 = cyc;
      rd(`MCCTB_OFF_CSR);
      wait_for(0, 1'b1, 100);
      `CHK(cyc - t0, P3)
      wr(`MCCTB_OFF_IRQ_MASK, 32'h0000_0000, 2'b00);
      rd(`MCCTB_OFF_IRQ_STAT);
      rd(`MCCTB_OFF_CSR);
      wait_for(0, 1'b1, 100);
      `CHK(irq, 1'b0)
      wr(`MCCTB_OFF_CSR, 32'h0000_000C, 2'b00);
      rd(`MCCTB_OFF_CSR);
      repeat (70) @(posedge aclk);
      rd_chk(`MCCTB_OFF_CSR, 32'h0000_000D, 2'b00);
      $display("test time base done");
      wr(`MCCTB_OFF_CSR, 32'h0000_000E, 2'b00);
      rd(`MCCTB_OFF_CSR);
      pulse(1);
      `CHK(power_state, 2'd1)
      rd_chk(`MCCTB_OFF_POWER, 32'h0000_0001, 2'b00);
      wait_for(3, 1'b1, 100);
      wr(`MCCTB_OFF_CSR, 32'h0000_008E, 2'b00);
      rd(`MCCTB_OFF_CSR);
      pulse(0);
      `CHK(power_state, 2'd2)
      wr(`MCCTB_OFF_CSR, 32'h0000_0000, 2'b00);
      lv = clock_out_pin;
      n = 0;
      while (power_state === 2'd2 && n < 100) begin
         `CHK(clock_out_pin, lv)
         @(posedge aclk);
         n++;
      end
      `CHK(power_state, 2'd0)
      rd(`MCCTB_OFF_CSR);
      `CHK(rdat & 32'hFFFF_FFFE, 32'h0000_008E)
      wr(`MCCTB_OFF_CSR, 32'h0000_000C, 2'b00);
      wr(`MCCTB_OFF_IRQ_MASK, 32'h0000_0001, 2'b00);
      wait_for(1, 1'b1, 100);
      rd(`MCCTB_OFF_CSR);
      rd(`MCCTB_OFF_IRQ_STAT);
      pulse(0);
      `CHK(power_state, 2'd3)
      repeat (150) @(posedge aclk);
      `CHK(power_state, 2'd3)
      pulse(2);
      wait_for(3, 1'b1, 10);
      rd_chk(`MCCTB_OFF_CSR, 32'h0000_000C, 2'b00);
      $display("test power modes done");
      for (int k = 1; k < 4; k++) begin
         wr(`MCCTB_OFF_TONE, 32'(k), 2'b00);
         `CHK(tone_sel, 1'b1)
         lv = tone_pin;
         wait_for(2, ~lv, 9000);
         t0 = cyc;
         wait_for(2, lv, 9000);
         `CHK(cyc - t0, 1000 << k)
      end
      wr(`MCCTB_OFF_TONE, 32'h0000_0000, 2'b00);
      `CHK(tone_sel, 1'b0)
      $display("test tone done");
      wr(`MCCTB_OFF_CSR, 32'h0000_000E, 2'b00);
      rd(`MCCTB_OFF_CSR);
      wait_for(0, 1'b1, 100);
      t0 = cyc;
      wr(`MCCTB_OFF_CSR, 32'h0000_0002, 2'b00);
      rd(`MCCTB_OFF_CSR);
      wait_for(0, 1'b1, 100);
      `CHK(cyc - t0, P3)
      t0 = cyc;
      rd(`MCCTB_OFF_CSR);
      wait_for(0, 1'b1, 17000);
      `CHK(cyc - t0, 16000)
      $display("test period change done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
